// [pkg/ocl_defines.svh]
`ifndef OCL_DEFINES_SVH
`define OCL_DEFINES_SVH

// Register indices; byte address is four times the index.
`define OCL_IDX_HIGH      8'h88
`define OCL_IDX_LOW       8'h89
`define OCL_IDX_SPARE     8'h8A
`define OCL_IDX_CFG1      8'h8B
`define OCL_IDX_STAT      8'h90

`define OCL_RST_HIGH      16'h7FFF
`define OCL_RST_LOW       16'h8000
`define OCL_RST_SPARE     16'h5555
`define OCL_RST_CFG1      16'h8010

`define OCL_POS_FS        16'h7FFF
`define OCL_NEG_FS        16'h8000

`define OCL_BIT_ON        15
`define OCL_BIT_CM        10
`define OCL_SRC_HI        9
`define OCL_SRC_LO        7
`define OCL_SNK_HI        6
`define OCL_SNK_LO        4
`define OCL_SRCL_HI       3
`define OCL_SRCL_LO       2
`define OCL_SNKL_HI       1
`define OCL_SNKL_LO       0
`define OCL_CFG1_WMASK    16'h87FF

`endif

// [pkg/ocl_pkg.sv]
package ocl_pkg;
   typedef logic [15:0] ocl_word_t;
   typedef struct packed {
      logic [15:0] high_limit;
      logic [15:0] low_limit;
      logic [15:0] spare;
      logic [15:0] cfg1;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        high_evt;
      logic        low_evt;
      logic        fault;
      logic [15:0] aux_result;
      logic [1:0]  aux_count;
      logic [7:0]  src_onehot;
      logic [7:0]  snk_onehot;
   } ocl_state_s;
endpackage

// [rtl/ocl_regbank.sv]
// Behaviour
// - High event when signed fast filter output exceeds the high limit.
// - High limit at positive full scale disables high detection.
// - Low event when signed fast filter output is below the low limit.
// - Low limit at negative full scale disables low detection; resets there.
// - Spare word is plain read/write, resets to 5555h, drives nothing.
// - Config bit 15 enables the aux converter; resets to one.
// - Disabled or standby clears aux result and sequence counter to zero.
// - Config bit 10 enables the common-mode buffer on input seven.
// - Bits 9:7 pick the source input, code n is input n, reset 0.
// - Bits 6:4 pick the sink input, reset selects input one.
// - Bits 3:2 set source level off/4/40/240 uA, reset off.
// - Bits 1:0 set sink level with the same encoding, reset off.
// - Config bits 14:11 are read-only and read zero.
// - Overcurrent fault is active when either limit event is active.
//
// Decided for this implementation: the APB register port.
`include "ocl_defines.svh"
module ocl_regbank
   import ocl_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   input  wire logic [15:0] fast_filter_out,
   input  wire logic        fast_filter_valid,
   input  wire logic [15:0] aux_conv_data,
   input  wire logic        aux_conv_valid,
   input  wire logic        standby_req,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             overcurrent_high_event,
   output logic             overcurrent_low_event,
   output logic             overcurrent_fault,
   output logic             aux_converter_on,
   output logic             common_mode_buffer_on,
   output logic [7:0]       openwire_source_onehot,
   output logic [7:0]       openwire_sink_onehot,
   output logic [1:0]       openwire_source_level,
   output logic [1:0]       openwire_sink_level,
   output logic [15:0]      aux_result,
   output logic [1:0]       aux_sequence_counter
);

   ocl_state_s st_r;
   ocl_state_s st_nxt;

   // One-hot decode shared by source and sink selects.
   function automatic logic [7:0] ocl_sel_decode(input logic [2:0] code);
      ocl_sel_decode = 8'h01 << code;
   endfunction

   // Byte-lane merge for 16-bit registers held in the low half word.
   function automatic ocl_word_t ocl_merge(input ocl_word_t old,
                                           input logic [31:0] wd,
                                           input logic [3:0] strb);
      ocl_merge = old;
      if (strb[0]) begin
         ocl_merge[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         ocl_merge[15:8] = wd[15:8];
      end
   endfunction

   logic [9:0] idx;
   logic       access;
   logic       hit;
   logic       aux_run;

   assign idx     = paddr[11:2];
   assign access  = psel && penable && !st_r.pready;
   assign aux_run = st_r.cfg1[`OCL_BIT_ON] && !standby_req;

   always_comb begin
      st_nxt         = st_r;
      st_nxt.pready  = access;
      st_nxt.pslverr = 1'b0;
      hit            = (idx == 10'(`OCL_IDX_HIGH)) ||
                       (idx == 10'(`OCL_IDX_LOW))  ||
                       (idx == 10'(`OCL_IDX_SPARE)) ||
                       (idx == 10'(`OCL_IDX_CFG1)) ||
                       (idx == 10'(`OCL_IDX_STAT));
      if (access) begin
         st_nxt.pslverr = !hit;
         st_nxt.prdata  = 32'h0000_0000;
         if (pwrite) begin
            unique case (idx)
               10'(`OCL_IDX_HIGH): begin
                  st_nxt.high_limit = ocl_merge(st_r.high_limit, pwdata,
                                                pstrb);
               end
               10'(`OCL_IDX_LOW): begin
                  st_nxt.low_limit = ocl_merge(st_r.low_limit, pwdata,
                                               pstrb);
               end
               10'(`OCL_IDX_SPARE): begin
                  st_nxt.spare = ocl_merge(st_r.spare, pwdata, pstrb);
               end
               10'(`OCL_IDX_CFG1): begin
                  // Reserved bits 14:11 are forced to zero on write.
                  st_nxt.cfg1 = ocl_merge(st_r.cfg1, pwdata, pstrb) &
                                `OCL_CFG1_WMASK;
               end
               default: begin
               end
            endcase
         end else begin
            unique case (idx)
               10'(`OCL_IDX_HIGH):  st_nxt.prdata = {16'h0000, st_r.high_limit};
               10'(`OCL_IDX_LOW):   st_nxt.prdata = {16'h0000, st_r.low_limit};
               10'(`OCL_IDX_SPARE): st_nxt.prdata = {16'h0000, st_r.spare};
               10'(`OCL_IDX_CFG1):  st_nxt.prdata = {16'h0000, st_r.cfg1};
               10'(`OCL_IDX_STAT): begin
                  st_nxt.prdata = {13'h0000, st_r.fault, st_r.low_evt,
                                   st_r.high_evt, st_r.aux_result};
               end
               default: begin
               end
            endcase
         end
      end

      // Comparators evaluate each new fast filter sample, signed compare.
      if (fast_filter_valid) begin
         st_nxt.high_evt = (st_r.high_limit != `OCL_POS_FS) &&
                           ($signed(fast_filter_out) >
                            $signed(st_r.high_limit));
         st_nxt.low_evt  = (st_r.low_limit != `OCL_NEG_FS) &&
                           ($signed(fast_filter_out) <
                            $signed(st_r.low_limit));
      end
      // Clearing a limit to its disable value drops a standing event too.
      if (st_r.high_limit == `OCL_POS_FS) begin
         st_nxt.high_evt = 1'b0;
      end
      if (st_r.low_limit == `OCL_NEG_FS) begin
         st_nxt.low_evt = 1'b0;
      end
      st_nxt.fault = st_nxt.high_evt || st_nxt.low_evt;

      if (!aux_run) begin
         st_nxt.aux_result = 16'h0000;
         st_nxt.aux_count  = 2'h0;
      end else if (aux_conv_valid) begin
         st_nxt.aux_result = aux_conv_data;
         st_nxt.aux_count  = st_r.aux_count + 2'h1;
      end

      st_nxt.src_onehot = ocl_sel_decode(
         st_nxt.cfg1[`OCL_SRC_HI:`OCL_SRC_LO]);
      st_nxt.snk_onehot = ocl_sel_decode(
         st_nxt.cfg1[`OCL_SNK_HI:`OCL_SNK_LO]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r            <= '0;
         st_r.high_limit <= `OCL_RST_HIGH;
         st_r.low_limit  <= `OCL_RST_LOW;
         st_r.spare      <= `OCL_RST_SPARE;
         st_r.cfg1       <= `OCL_RST_CFG1;
         st_r.src_onehot <= 8'h01;
         st_r.snk_onehot <= 8'h02;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pready                 = st_r.pready;
   assign prdata                 = st_r.prdata;
   assign pslverr                = st_r.pslverr;
   assign overcurrent_high_event = st_r.high_evt;
   assign overcurrent_low_event  = st_r.low_evt;
   assign overcurrent_fault      = st_r.fault;
   assign aux_converter_on       = st_r.cfg1[`OCL_BIT_ON];
   assign common_mode_buffer_on  = st_r.cfg1[`OCL_BIT_CM];
   assign openwire_source_onehot = st_r.src_onehot;
   assign openwire_sink_onehot   = st_r.snk_onehot;
   assign openwire_source_level  =
      st_r.cfg1[`OCL_SRCL_HI:`OCL_SRCL_LO];
   assign openwire_sink_level    =
      st_r.cfg1[`OCL_SNKL_HI:`OCL_SNKL_LO];
   assign aux_result             = st_r.aux_result;
   assign aux_sequence_counter   = st_r.aux_count;

endmodule // ocl_regbank

// [verification/ocl_regbank_monitor.sv]
module ocl_regbank_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic [15:0] fast_filter_out,
   input wire logic        fast_filter_valid,
   input wire logic [15:0] aux_conv_data,
   input wire logic        aux_conv_valid,
   input wire logic        standby_req,
   input wire logic        overcurrent_high_event,
   input wire logic        overcurrent_low_event,
   input wire logic        overcurrent_fault,
   input wire logic        aux_converter_on,
   input wire logic [15:0] aux_result,
   input wire logic [1:0]  aux_sequence_counter
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered after one cycle");
   ready_once_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   fault_either_a: assert property (overcurrent_fault ==
      (overcurrent_high_event || overcurrent_low_event))
      else $error("fault differs from event pair");
   high_full_a: assert property (fast_filter_valid &&
      fast_filter_out == 16'h7FFF |=> !overcurrent_high_event)
      else $error("high event on full scale sample");
   low_full_a: assert property (fast_filter_valid &&
      fast_filter_out == 16'h8000 |=> !overcurrent_low_event)
      else $error("low event on negative full scale sample");
   high_cause_a: assert property ($rose(overcurrent_high_event) |->
      $past(fast_filter_valid)) else $error("high event rose without sample");
   aux_clear_a: assert property (!aux_converter_on || standby_req |=>
      aux_result == 16'h0000 && aux_sequence_counter == 2'h0)
      else $error("aux result not cleared");
   aux_load_a: assert property (aux_converter_on && !standby_req &&
      aux_conv_valid |=> aux_result == $past(aux_conv_data) &&
      aux_sequence_counter == 2'($past(aux_sequence_counter) + 2'h1))
      else $error("aux result or counter not loaded");
endmodule // ocl_regbank_monitor

// [verification/test_ocl_regbank.sv]
module test_ocl_regbank;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic fast_filter_valid, aux_conv_valid, standby_req, overcurrent_fault;
   logic overcurrent_high_event, overcurrent_low_event, aux_converter_on;
   logic common_mode_buffer_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  pstrb;
   logic [15:0] fast_filter_out, aux_conv_data, aux_result;
   logic [7:0]  openwire_source_onehot, openwire_sink_onehot;
   logic [1:0]  openwire_source_level, openwire_sink_level;
   logic [1:0]  aux_sequence_counter;
   int err_total, comparisons;
   ocl_regbank ocl_regbank_inst (.*);
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // The request stays up until pready is seen at an edge.
   task automatic xfer(input logic w, input logic [7:0] i, input logic [15:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= {2'h0, i, 2'h0};
      pwdata <= {16'h0000, d};
      @(posedge pclk) penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin err_total++; print_verdict(); end
      rdat = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] i, input logic [15:0] e);
      xfer(1'b0, i, 16'h0000);
      chk("read data", {16'h0000, e}, rdat);
   endtask
   task automatic smp(input logic [15:0] d, input logic h, l);
      @(posedge pclk) fast_filter_out <= d;
      fast_filter_valid <= 1'b1;
      @(posedge pclk) fast_filter_valid <= 1'b0;
      @(posedge pclk) chk("high event", h, overcurrent_high_event);
      chk("low event", l, overcurrent_low_event);
      chk("fault", h | l, overcurrent_fault);
   endtask
   initial begin pclk = 1'b0; forever #5 pclk = ~pclk; end
   initial begin
      {presetn, psel, penable, pwrite, fast_filter_valid} = '0;
      {aux_conv_valid, standby_req, paddr, pwdata, fast_filter_out} = '0;
      aux_conv_data = '0; pstrb = 4'h3;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h88, 16'h7FFF);
      rd(8'h89, 16'h8000);
      rd(8'h8A, 16'h5555);
      rd(8'h8B, 16'h8010);
      chk("sink onehot", 8'h02, openwire_sink_onehot);
      xfer(1'b1, 8'h8B, 16'hFFFF);
      rd(8'h8B, 16'h87FF);
      chk("buffer", 1'b1, common_mode_buffer_on);
      for (int n = 0; n < 8; n++) begin
         xfer(1'b1, 8'h8B, 16'((n << 7) | ((7 - n) << 4) | (n & 3) * 5));
         repeat (2) @(posedge pclk);
         chk("source onehot", 8'h01 << n, openwire_source_onehot);
         chk("sink onehot", 8'h80 >> n, openwire_sink_onehot);
         chk("source level", n & 3, openwire_source_level);
         chk("sink level", n & 3, openwire_sink_level);
      end
      xfer(1'b1, 8'h8A, 16'hAAAA);
      rd(8'h8A, 16'hAAAA);
      rd(8'h87, 16'h0000);
      chk("error response", 1'b1, pslverr);
      xfer(1'b1, 8'h88, 16'h0010);
      xfer(1'b1, 8'h89, 16'hFFF0);
      smp(16'h0011, 1'b1, 1'b0);
      smp(16'h0010, 1'b0, 1'b0);
      smp(16'hFFEF, 1'b0, 1'b1);
      smp(16'hFFF0, 1'b0, 1'b0);
      xfer(1'b1, 8'h88, 16'h7FFF);
      xfer(1'b1, 8'h89, 16'h8000);
      smp(16'h7FFF, 1'b0, 1'b0);
      smp(16'h8000, 1'b0, 1'b0);
      xfer(1'b1, 8'h8B, 16'h8010);
      @(posedge pclk) aux_conv_data <= 16'h1234;
      aux_conv_valid <= 1'b1;
      repeat (2) @(posedge pclk);
      aux_conv_valid <= 1'b0;
      @(posedge pclk) chk("aux result", 16'h1234, aux_result);
      chk("aux count", 2'h2, aux_sequence_counter);
      standby_req <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("aux count", 2'h0, aux_sequence_counter);
      standby_req <= 1'b0;
      @(posedge pclk) aux_conv_valid <= 1'b1;
      @(posedge pclk) aux_conv_valid <= 1'b0;
      xfer(1'b1, 8'h8B, 16'h0010);
      repeat (2) @(posedge pclk);
      chk("aux result", 16'h0000, aux_result);
      chk("converter on", 1'b0, aux_converter_on);
      print_verdict();
   end
endmodule // test_ocl_regbank
bind ocl_regbank ocl_regbank_monitor ocl_regbank_monitor_inst (.*);
